// [acq_pkg.sv]
// constants, codes and types shared by the acquisition control block
// assumes one clock domain, core_clk at 50 MHz
`default_nettype none
package acq_pkg;
	// =====================================================
	// widths and depths
	localparam int WORD_W = 16;
	localparam int STD_DATA_W = 12;
	localparam int CNT_W = 16;
	localparam int CHAN_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int SYNC_STAGES = 3;
	// =====================================================
	// transfer mode codes on xfer_mode
	localparam logic [1:0] XFER_DMA_NONCYC = 2'h1;
	// =====================================================
	// counts per input range
	localparam logic [16:0] FULL_SCALE_STD = 17'h01000;
	localparam logic [16:0] FULL_SCALE_HR = 17'h10000;
	// =====================================================
	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CHAN_W-1:0] CHAN_RST = 8'h00;
	localparam logic [CNT_W-1:0] TRIG_INDEX_NONE = 16'h0000;
	// =====================================================
	// end cause codes on end_cause
	localparam logic [2:0] END_NONE = 3'h0;
	localparam logic [2:0] END_TOTAL = 3'h1;
	localparam logic [2:0] END_POST = 3'h2;
	localparam logic [2:0] END_STOP = 3'h3;
	localparam logic [2:0] END_ERROR = 3'h4;
	// =====================================================
	// acquisition states
	typedef enum {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} acq_state_e;
endpackage
`default_nettype wire

// [sample_if.sv]
// valid/ready word carrier between formatter and sample fifo
// assumes both ends on core_clk
`default_nettype none
interface sample_if;
	import acq_pkg::*;
	logic valid;
	logic ready;
	logic [WORD_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [sample_formatter.sv]
// one register stage that codes a converter result as a fifo word
// assumes conv_valid is held until conv_ready
`default_nettype none
module sample_formatter
	import acq_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// converter side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WORD_W-1:0] in_data,
	input wire logic in_bipolar,
	input wire logic hi_res,
	// word side
	sample_if.src out
);
	logic out_valid_ff, nxt_out_valid;
	logic [WORD_W-1:0] out_data_ff, nxt_out_data;

	function automatic logic [WORD_W-1:0] code_word(input logic [WORD_W-1:0] d,
		input logic bip, input logic hr);
		if (hr)
			code_word = d;
		else if (bip)
			code_word = {{(WORD_W-STD_DATA_W){d[STD_DATA_W-1]}}, d[STD_DATA_W-1:0]};
		else
			code_word = {{(WORD_W-STD_DATA_W){1'b0}}, d[STD_DATA_W-1:0]};
	endfunction

	// =====================================================
	// stage
	assign in_ready = !out_valid_ff || out.ready;
	always_comb begin
		nxt_out_valid = out_valid_ff;
		nxt_out_data = out_data_ff;
		if (in_ready) begin
			nxt_out_valid = in_valid;
			if (in_valid)
				nxt_out_data = code_word(in_data, in_bipolar, hi_res);
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= 16'h0000;
		end else begin
			out_valid_ff <= nxt_out_valid;
			out_data_ff <= nxt_out_data;
		end
	end
	assign out.valid = out_valid_ff;
	assign out.data = out_data_ff;
endmodule
`default_nettype wire

// [sample_fifo.sv]
// flip-flop fifo, width and depth as parameters
// assumes depth is a power of two
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// fill side
	sample_if.snk in,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	assign in.ready = (cnt_ff != DEPTH[AW:0]);
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
	assign push = in.valid && in.ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
		nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop)
			nxt_cnt = cnt_ff + 1'b1;
		else if (pop && !push)
			nxt_cnt = cnt_ff - 1'b1;
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end
	// storage holds no reset; words are only read once written
	always_ff @(posedge core_clk) begin
		if (push)
			mem_ff[wr_ff] <= in.data;
	end
endmodule
`default_nettype wire

// [about_trigger_acquisition.sv]
// acquisition control: word coding, thresholds, about-trigger sequencing
// assumes converter results arrive with valid/ready and pins are asynchronous
`default_nettype none
// Operation
// - each conversion result enters the sample fifo as one 16-bit word per channel.
// - standard resolution carries 12 data bits per word, high resolution all 16.
// - in standard resolution a unipolar channel gives a positive 12-bit magnitude with the upper four bits zero.
// - a bipolar channel gives a two's complement data field.
// - level and hysteresis are counts of range/4096 or range/65536.
// - software or an external start begins a run, and the trigger pin gives the event.
// - on the event the run collects the set number of post samples per channel.
// - reaching the total count with no event ends the run with index 0.
// - event plus all post samples ends the run and reports the trigger position.
// - running out of total count first still ends the run and reports the position.
// - a stop request or an error ends the run at once.
// - about-trigger works only in non-cyclic dma transfer mode.
// - internal pacing converts at once, an external clock arms for its next falling edge.
module about_trigger_acquisition
	import acq_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// configuration
	input wire logic hi_res,
	input wire logic [1:0] xfer_mode,
	input wire logic ext_clk_sel,
	input wire logic [CNT_W-1:0] total_count,
	input wire logic [CNT_W-1:0] post_per_chan,
	input wire logic [CHAN_W-1:0] num_chans,
	input wire logic [CNT_W-1:0] level_count,
	input wire logic [CNT_W-1:0] hyst_count,
	// control
	input wire logic start_sw,
	input wire logic stop_req,
	input wire logic error_in,
	// pins
	input wire logic ext_start_pin,
	input wire logic trigger_input_pin,
	input wire logic ext_conv_clk_pin,
	// converter
	input wire logic conv_valid,
	output logic conv_ready,
	input wire logic [WORD_W-1:0] conv_data,
	input wire logic conv_bipolar,
	output logic conv_go,
	// sample fifo drain to dma
	output logic dma_valid,
	input wire logic dma_ready,
	output logic [WORD_W-1:0] dma_data,
	// status
	output logic acq_active,
	output logic acq_done,
	output logic trig_seen,
	output logic [CNT_W-1:0] trig_index,
	output logic [2:0] end_cause,
	output logic about_en,
	output logic [16:0] thr_rearm_pos,
	output logic [16:0] thr_rearm_neg,
	output logic thr_ok
);
	// =====================================================
	// pin synchronisers
	localparam int NPIN = 3;
	logic [NPIN-1:0] pin_raw;
	logic [SYNC_STAGES-1:0] sync_ff [NPIN];
	logic [NPIN-1:0] pin_lvl_ff, nxt_pin_lvl, pin_rise, pin_fall;

	assign pin_raw = {ext_conv_clk_pin, trigger_input_pin, ext_start_pin};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (!rstn)
					sync_ff[gi] <= '0;
				else
					sync_ff[gi] <= {sync_ff[gi][SYNC_STAGES-2:0], pin_raw[gi]};
			end
			// a change counts only once the last two stages agree
			always_comb begin
				nxt_pin_lvl[gi] = pin_lvl_ff[gi];
				if (sync_ff[gi][1] == sync_ff[gi][2])
					nxt_pin_lvl[gi] = sync_ff[gi][2];
			end
			assign pin_rise[gi] = nxt_pin_lvl[gi] && !pin_lvl_ff[gi];
			assign pin_fall[gi] = !nxt_pin_lvl[gi] && pin_lvl_ff[gi];
		end
	endgenerate
	always_ff @(posedge core_clk) begin
		if (!rstn)
			pin_lvl_ff <= '0;
		else
			pin_lvl_ff <= nxt_pin_lvl;
	end

	logic start_ev, trig_ev_raw, ext_clk_fall;
	assign start_ev = start_sw || pin_rise[0];
	assign trig_ev_raw = pin_rise[1];
	assign ext_clk_fall = pin_fall[2];

	// =====================================================
	// thresholds in count units
	logic [16:0] full_scale, nxt_pos, nxt_neg;
	logic nxt_thr_ok;
	logic [16:0] thr_pos_ff, thr_neg_ff;
	logic thr_ok_ff;
	always_comb begin
		full_scale = hi_res ? FULL_SCALE_HR : FULL_SCALE_STD;
		// hysteresis is an unsigned magnitude; window must stay inside the unipolar range
		nxt_pos = {1'b0, level_count} - {1'b0, hyst_count};
		nxt_neg = {1'b0, level_count} + {1'b0, hyst_count};
		nxt_thr_ok = ({1'b0, level_count} >= {1'b0, hyst_count}) && (nxt_neg < full_scale);
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			thr_pos_ff <= 17'h00000;
			thr_neg_ff <= 17'h00000;
			thr_ok_ff <= 1'b0;
		end else begin
			thr_pos_ff <= nxt_pos;
			thr_neg_ff <= nxt_neg;
			thr_ok_ff <= nxt_thr_ok;
		end
	end
	assign thr_rearm_pos = thr_pos_ff;
	assign thr_rearm_neg = thr_neg_ff;
	assign thr_ok = thr_ok_ff;

	// =====================================================
	// word path
	sample_if fmt_q ();
	logic fmt_in_ready, take;

	sample_formatter u_fmt (
		.core_clk(core_clk),
		.rstn(rstn),
		.in_valid(conv_valid && conv_go),
		.in_ready(fmt_in_ready),
		.in_data(conv_data),
		.in_bipolar(conv_bipolar),
		.hi_res(hi_res),
		.out(fmt_q)
	);
	// a full fifo stalls the formatter and then the converter
	sample_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.in(fmt_q),
		.out_valid(dma_valid),
		.out_ready(dma_ready),
		.out_data(dma_data)
	);
	assign conv_ready = fmt_in_ready && conv_go;
	assign take = conv_valid && conv_ready;

	// =====================================================
	// sequencer
	acq_state_e state_ff, nxt_state;
	logic [CNT_W-1:0] total_ff, nxt_total, post_ff, nxt_post, index_ff, nxt_index;
	logic [CHAN_W-1:0] chan_ff, nxt_chan;
	logic seen_ff, nxt_seen, about_ff, nxt_about;
	logic [2:0] cause_ff, nxt_cause;
	logic last_total, scan_wrap, trig_ev;

	// mode gate sampled at start so a run keeps its setting
	assign about_en = (xfer_mode == XFER_DMA_NONCYC) && (post_per_chan != CNT_RST);
	assign last_total = take && (total_ff + 1'b1 == total_count);
	assign scan_wrap = take && (chan_ff + 1'b1 >= num_chans);
	assign trig_ev = trig_ev_raw && about_ff && !seen_ff && (state_ff == ST_RUN);

	always_comb begin
		nxt_state = state_ff;
		nxt_total = total_ff;
		nxt_post = post_ff;
		nxt_chan = chan_ff;
		nxt_seen = seen_ff;
		nxt_index = index_ff;
		nxt_about = about_ff;
		nxt_cause = cause_ff;
		case (state_ff)
			ST_IDLE, ST_DONE: begin
				if (start_ev) begin
					nxt_total = CNT_RST;
					nxt_post = CNT_RST;
					nxt_chan = CHAN_RST;
					nxt_seen = 1'b0;
					nxt_index = TRIG_INDEX_NONE;
					nxt_about = about_en;
					nxt_cause = END_NONE;
					nxt_state = ext_clk_sel ? ST_ARMED : ST_RUN;
				end
			end
			ST_ARMED: begin
				if (stop_req || error_in) begin
					nxt_cause = error_in ? END_ERROR : END_STOP;
					nxt_state = ST_DONE;
				end else if (ext_clk_fall)
					nxt_state = ST_RUN;
			end
			ST_RUN: begin
				if (take) begin
					nxt_total = total_ff + 1'b1;
					nxt_chan = scan_wrap ? CHAN_RST : chan_ff + 1'b1;
					if (seen_ff && scan_wrap)
						nxt_post = post_ff + 1'b1;
				end
				if (trig_ev) begin
					nxt_seen = 1'b1;
					nxt_index = total_ff;
				end
				if (stop_req || error_in) begin
					nxt_cause = error_in ? END_ERROR : END_STOP;
					nxt_state = ST_DONE;
				end else if (seen_ff && scan_wrap && (post_ff + 1'b1 >= post_per_chan)) begin
					nxt_cause = END_POST;
					nxt_state = ST_DONE;
				end else if (last_total) begin
					nxt_cause = END_TOTAL;
					nxt_state = ST_DONE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			total_ff <= CNT_RST;
			post_ff <= CNT_RST;
			chan_ff <= CHAN_RST;
			seen_ff <= 1'b0;
			index_ff <= TRIG_INDEX_NONE;
			about_ff <= 1'b0;
			cause_ff <= END_NONE;
		end else begin
			state_ff <= nxt_state;
			total_ff <= nxt_total;
			post_ff <= nxt_post;
			chan_ff <= nxt_chan;
			seen_ff <= nxt_seen;
			index_ff <= nxt_index;
			about_ff <= nxt_about;
			cause_ff <= nxt_cause;
		end
	end

	assign conv_go = (state_ff == ST_RUN);
	assign acq_active = (state_ff == ST_RUN) || (state_ff == ST_ARMED);
	assign acq_done = (state_ff == ST_DONE);
	assign trig_seen = seen_ff;
	assign trig_index = index_ff;
	assign end_cause = cause_ff;

	// =====================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_running;
		state_ff == ST_RUN;
	endsequence
	sequence s_stop_now;
		stop_req || error_in;
	endsequence
	sequence s_armed_fall;
		state_ff == ST_ARMED ##0 ext_clk_fall && !stop_req && !error_in;
	endsequence

	AST_STD_UNIPOLAR: assert property (
		fmt_q.valid && !hi_res && !$past(conv_bipolar) && $past(take)
		|-> fmt_q.data[15:12] == 4'h0)
		else $error("unipolar word has nonzero upper bits");
	AST_STD_BIPOLAR: assert property (
		$past(take) && !hi_res && $past(conv_bipolar) && $past(fmt_in_ready)
		|-> fmt_q.data == {{4{$past(conv_data[11])}}, $past(conv_data[11:0])})
		else $error("bipolar word not sign extended");
	AST_HR_PASS: assert property (
		$past(take) && hi_res |-> fmt_q.data == $past(conv_data))
		else $error("high resolution word altered");
	AST_STOP_ENDS: assert property (
		s_running ##0 s_stop_now |=> acq_done && !conv_go)
		else $error("stop did not end the run");
	AST_NO_TRIG_INDEX: assert property (
		acq_done && end_cause == END_TOTAL && !trig_seen |-> trig_index == 16'h0000)
		else $error("index nonzero without trigger");
	AST_INDEX_LATCH: assert property (
		trig_ev && !(stop_req || error_in) |=> trig_seen && trig_index == $past(total_ff))
		else $error("trigger index not latched");
	AST_MODE_GATE: assert property (
		xfer_mode != XFER_DMA_NONCYC |-> !about_en)
		else $error("about mode enabled outside non-cyclic dma");
	AST_EXT_ARM: assert property (
		state_ff == ST_ARMED && !ext_clk_fall && !stop_req && !error_in |=> !conv_go)
		else $error("converting before external clock edge");
	AST_EXT_GO: assert property (
		s_armed_fall |=> conv_go)
		else $error("no start at external falling edge");
	AST_TOTAL_END: assert property (
		s_running ##0 last_total && !stop_req && !error_in |=> acq_done)
		else $error("run passed the total count");
	// checked on entry to done only: the host may load a new post setting while done
	AST_POST_HOLD: assert property (
		$rose(acq_done) && end_cause == END_POST |-> trig_seen && post_ff >= post_per_chan)
		else $error("post end without enough samples");
endmodule
`default_nettype wire

// [host_dma_model.sv]
// host side model: dma word sink with stall and slow modes, trigger pin source
// assumes core_clk is the block clock; words are taken on its rising edge
`default_nettype none
module host_dma_model
	import acq_pkg::*;
(
	// clock
	input wire logic core_clk,
	// dma side
	input wire logic dma_valid,
	output logic dma_ready,
	input wire logic [WORD_W-1:0] dma_data,
	// test control
	input wire logic stall,
	input wire logic slow,
	// trigger pin
	output logic trig_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [WORD_W-1:0] got[$];
	initial begin
		dma_ready = 1'b0;
		trig_pin = 1'b0;
	end
	// =====================================================
	// sink: a word counts only on an edge with ready high
	always @(posedge core_clk) begin
		if (dma_valid === 1'b1 && dma_ready) begin
			got.push_back(dma_data);
		end
		dma_ready <= !stall && (!slow || !dma_ready);
	end
	// =====================================================
	// pulse held long enough to pass the pin synchroniser
	task automatic fire_trigger();
		@(negedge core_clk);
		trig_pin = 1'b1;
		repeat (5) @(negedge core_clk);
		trig_pin = 1'b0;
	endtask
endmodule
`default_nettype wire

// [about_trigger_acquisition_tb.sv]
// self-checking bench for the acquisition control block
// assumes host_dma_model as far side; inputs change on falling edges
`default_nettype none
module about_trigger_acquisition_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import acq_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, hi_res = 1'b0, ext_clk_sel = 1'b0;
	logic [1:0] xfer_mode = 2'h1;
	logic [CNT_W-1:0] total_count = 16'h0004, post_per_chan = 16'h0000;
	logic [CNT_W-1:0] level_count = 16'h0000, hyst_count = 16'h0000;
	logic [CHAN_W-1:0] num_chans = 8'h01;
	logic start_sw = 1'b0, stop_req = 1'b0, error_in = 1'b0, ext_start_pin = 1'b0;
	logic ext_conv_clk_pin = 1'b0, conv_valid = 1'b0, conv_bipolar = 1'b0;
	logic stall = 1'b0, slow = 1'b0;
	logic [WORD_W-1:0] conv_data = 16'h0000;
	wire logic conv_ready, conv_go, dma_valid, dma_ready, trigger_input_pin;
	wire logic acq_active, acq_done, trig_seen, about_en, thr_ok;
	wire logic [WORD_W-1:0] dma_data;
	wire logic [CNT_W-1:0] trig_index;
	wire logic [2:0] end_cause;
	wire logic [16:0] thr_rearm_pos, thr_rearm_neg;
	int err_total = 0, comparisons = 0;
	logic [WORD_W-1:0] exp_q[$];

	always #10 core_clk = ~core_clk;

	about_trigger_acquisition u_about_trigger_acquisition (.core_clk(core_clk), .rstn(rstn),
		.hi_res(hi_res), .xfer_mode(xfer_mode), .ext_clk_sel(ext_clk_sel),
		.total_count(total_count), .post_per_chan(post_per_chan), .num_chans(num_chans),
		.level_count(level_count), .hyst_count(hyst_count), .start_sw(start_sw),
		.stop_req(stop_req), .error_in(error_in), .ext_start_pin(ext_start_pin),
		.trigger_input_pin(trigger_input_pin), .ext_conv_clk_pin(ext_conv_clk_pin),
		.conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data),
		.conv_bipolar(conv_bipolar), .conv_go(conv_go), .dma_valid(dma_valid),
		.dma_ready(dma_ready), .dma_data(dma_data), .acq_active(acq_active),
		.acq_done(acq_done), .trig_seen(trig_seen), .trig_index(trig_index),
		.end_cause(end_cause), .about_en(about_en), .thr_rearm_pos(thr_rearm_pos),
		.thr_rearm_neg(thr_rearm_neg), .thr_ok(thr_ok));

	host_dma_model u_host_dma_model (.core_clk(core_clk), .dma_valid(dma_valid),
		.dma_ready(dma_ready), .dma_data(dma_data), .stall(stall), .slow(slow),
		.trig_pin(trigger_input_pin));

	// =====================================================
	// reporting
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic hang(string s);
		err_total++;
		$display("[ERR] %0t timeout %s", $time, s);
		conclude();
	endtask

	task automatic chk(logic [16:0] got, logic [16:0] exp, string s);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask

	// =====================================================
	// converter and run helpers
	function automatic logic [WORD_W-1:0] fmt(logic [WORD_W-1:0] d);
		if (hi_res) return d;
		return conv_bipolar ? {{4{d[11]}}, d[11:0]} : {4'h0, d[11:0]};
	endfunction

	// holds the word until an edge with ready, leaves valid up
	// ready only moves on rising edges, so it is read settled at the falling edge
	task automatic conv_word(logic [WORD_W-1:0] d, logic bip);
		@(negedge core_clk);
		conv_valid = 1'b1;
		conv_data = d;
		conv_bipolar = bip;
		for (int i = 0; i < 60; i++) begin
			if (conv_ready === 1'b1) begin
				@(posedge core_clk);
				exp_q.push_back(fmt(d));
				return;
			end
			@(negedge core_clk);
		end
		hang("conv");
	endtask

	task automatic idle();
		@(negedge core_clk);
		conv_valid = 1'b0;
	endtask

	task automatic start_run(logic [CNT_W-1:0] tot, logic [CNT_W-1:0] post);
		@(negedge core_clk);
		total_count = tot;
		post_per_chan = post;
		start_sw = 1'b1;
		@(negedge core_clk);
		start_sw = 1'b0;
		chk(conv_go, 1'b1, "internal start");
	endtask

	task automatic wait_done();
		for (int i = 0; i < 60; i++) begin
			@(negedge core_clk);
			if (acq_done === 1'b1) return;
		end
		hang("done");
	endtask

	task automatic check_words();
		for (int i = 0; i < 80 && u_host_dma_model.got.size() < exp_q.size(); i++) begin
			@(negedge core_clk);
		end
		chk(u_host_dma_model.got.size(), exp_q.size(), "word count");
		foreach (exp_q[i]) begin
			if (i < u_host_dma_model.got.size()) begin
				chk(u_host_dma_model.got[i], exp_q[i], "word");
			end
		end
		u_host_dma_model.got.delete();
		exp_q.delete();
	endtask

	task automatic check_end(logic [2:0] cause, logic [CNT_W-1:0] idx, logic seen);
		chk(end_cause, cause, "end cause");
		chk(trig_index, idx, "trigger index");
		chk(trig_seen, seen, "trigger seen");
	endtask

	// =====================================================
	// scenarios
	task automatic t_format_fill();
		bit refused;
		hi_res = 1'b0;
		stall = 1'b1;
		start_run(16'h000C, 16'h0000);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			conv_word(16'hF7A0 + 16'(i * 16'h0111), i[0]);
		end
		@(negedge core_clk);
		conv_data = 16'h5801;
		conv_bipolar = 1'b1;
		refused = 1'b1;
		repeat (6) @(posedge core_clk) if (conv_ready === 1'b1) refused = 1'b0;
		chk(refused, 1'b1, "full buffer accepts");
		stall = 1'b0;
		slow = 1'b1;
		conv_word(16'h5801, 1'b1);
		conv_word(16'h0FFF, 1'b0);
		conv_word(16'h0800, 1'b1);
		idle();
		wait_done();
		check_end(END_TOTAL, TRIG_INDEX_NONE, 1'b0);
		check_words();
		hi_res = 1'b1;
		start_run(16'h0002, 16'h0000);
		conv_word(16'h8001, 1'b1);
		conv_word(16'hFFFF, 1'b0);
		idle();
		wait_done();
		check_words();
		slow = 1'b0;
		hi_res = 1'b0;
		$display("test format_fill done");
	endtask

	// trigger after pre samples, then post or total ends the run
	task automatic t_about(logic [CNT_W-1:0] tot, int pre, int post, int fed, logic [2:0] c);
		start_run(tot, 16'(post));
		for (int i = 0; i < pre; i++) conv_word(16'(i), 1'b0);
		idle();
		u_host_dma_model.fire_trigger();
		repeat (6) @(negedge core_clk);
		for (int i = 0; i < fed; i++) begin
			chk(acq_done, 1'b0, "early end");
			conv_word(16'(i + 16'h0100), 1'b0);
		end
		idle();
		wait_done();
		check_end(c, 16'(pre), 1'b1);
		check_words();
		$display("test about done");
	endtask

	task automatic t_stop(logic err);
		start_run(16'h0014, 16'h0000);
		conv_word(16'h0123, 1'b0);
		// valid drops with the stop so the taken word is not offered twice
		idle();
		stop_req = 1'b1;
		error_in = err;
		@(negedge core_clk);
		chk(acq_done, 1'b1, "stop latency");
		chk(conv_go, 1'b0, "conversions after stop");
		chk(end_cause, err ? END_ERROR : END_STOP, "stop cause");
		stop_req = 1'b0;
		error_in = 1'b0;
		check_words();
		$display("test stop done");
	endtask

	task automatic t_mode();
		for (int m = 0; m < 4; m++) begin
			@(negedge core_clk);
			xfer_mode = 2'(m);
			post_per_chan = 16'h0003;
			@(negedge core_clk);
			chk(about_en, m == 1, "about enable");
		end
		post_per_chan = 16'h0000;
		xfer_mode = XFER_DMA_NONCYC;
		@(negedge core_clk);
		chk(about_en, 1'b0, "zero post setting");
		xfer_mode = 2'h2;
		t_about_off();
		xfer_mode = XFER_DMA_NONCYC;
		$display("test mode done");
	endtask

	task automatic t_about_off();
		start_run(16'h0003, 16'h0003);
		conv_word(16'h0011, 1'b0);
		idle();
		u_host_dma_model.fire_trigger();
		repeat (6) @(negedge core_clk);
		conv_word(16'h0022, 1'b0);
		conv_word(16'h0033, 1'b0);
		idle();
		wait_done();
		check_end(END_TOTAL, TRIG_INDEX_NONE, 1'b0);
		check_words();
	endtask

	task automatic t_extclk();
		ext_clk_sel = 1'b1;
		@(negedge core_clk);
		ext_start_pin = 1'b1;
		repeat (5) @(negedge core_clk);
		ext_start_pin = 1'b0;
		chk(acq_active, 1'b1, "pin start");
		repeat (4) @(negedge core_clk);
		chk(conv_go, 1'b0, "armed waits for clock edge");
		ext_conv_clk_pin = 1'b1;
		repeat (6) @(negedge core_clk);
		chk(conv_go, 1'b0, "rising clock edge starts");
		ext_conv_clk_pin = 1'b0;
		for (int i = 0; i < 8 && conv_go !== 1'b1; i++) @(negedge core_clk);
		chk(conv_go, 1'b1, "falling clock edge starts");
		stop_req = 1'b1;
		@(negedge core_clk);
		stop_req = 1'b0;
		ext_clk_sel = 1'b0;
		$display("test extclk done");
	endtask

	task automatic t_thr();
		logic [CNT_W-1:0] lv[5] = '{16'h0064, 16'h000A, 16'h0FFA, 16'h0FFA, 16'h0FF5};
		logic [CNT_W-1:0] hy[5] = '{16'h0029, 16'h0029, 16'h000A, 16'h000A, 16'h000A};
		logic hr[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		logic ok[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		for (int i = 0; i < 5; i++) begin
			@(negedge core_clk);
			level_count = lv[i];
			hyst_count = hy[i];
			hi_res = hr[i];
			repeat (2) @(negedge core_clk);
			chk(thr_ok, ok[i], "threshold ok");
			chk(thr_rearm_neg, {1'b0, lv[i]} + {1'b0, hy[i]}, "rearm above");
			if (ok[i]) chk(thr_rearm_pos, {1'b0, lv[i]} - {1'b0, hy[i]}, "rearm below");
		end
		hi_res = 1'b0;
		$display("test thr done");
	endtask

	// =====================================================
	// main sequence
	initial begin
		repeat (2) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		t_format_fill();
		t_about(16'h0014, 5, 3, 3, END_POST);
		t_about(16'h0006, 4, 5, 2, END_TOTAL);
		num_chans = 8'h02;
		t_about(16'h0014, 4, 2, 4, END_POST);
		num_chans = 8'h01;
		t_stop(1'b0);
		t_stop(1'b1);
		t_mode();
		t_extclk();
		t_thr();
		conclude();
	end
endmodule
`default_nettype wire
